/* shared/fscr_pkg.sv */
// constants for the flash status and configuration register block
package fscr_pkg;
   // instruction codes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
   localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
   localparam logic [7:0] OP_READ_STATUS3 = 8'h15;
   localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
   localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
   localparam logic [7:0] OP_WRITE_STATUS3 = 8'h11;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PERM_LOCK = 8'hF3;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_SEC_REG_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_REG_PROG = 8'h42;
   // status one bit positions
   localparam int SR1_BUSY = 0;
   localparam int SR1_WEL = 1;
   localparam int SR1_LVL_LSB = 2;
   localparam int SR1_LVL_MSB = 4;
   localparam int SR1_TB = 5;
   localparam int SR1_SEC = 6;
   localparam int SR1_SRP = 7;
   // status two bit positions
   localparam int SR2_SRL = 0;
   localparam int SR2_QE = 1;
   localparam int SR2_CMP = 6;
   // power-up values of the stored fields
   localparam logic [2:0] RST_PROT_LEVEL = 3'h0;
   localparam logic RST_TOP_BOTTOM = 1'b0;
   localparam logic RST_GRANULARITY = 1'b0;
   localparam logic RST_COMPLEMENT = 1'b0;
   localparam logic RST_STATUS_PROTECT = 1'b0;
   localparam logic RST_QUAD_ENABLE = 1'b0;
   localparam logic [7:0] RST_STATUS_THREE = 8'h00;
   // synchroniser idle values: clk, cs_n, di, wp_n
   localparam logic [3:0] SYNC_RST = 4'h4;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] BYTE_CNT_MAX = 2'h3;
   // operation times
   localparam int CORE_CLK_MHZ = 40;
   localparam int T_STATUS_WRITE_US = 15;
   localparam int T_ARRAY_OP_US = 3000;
   localparam int TIMER_W = 24;
   localparam int STATUS_WRITE_CYCLES = T_STATUS_WRITE_US * CORE_CLK_MHZ;
   localparam int ARRAY_OP_CYCLES = T_ARRAY_OP_US * CORE_CLK_MHZ;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b11,
      ST_IGNORE = 2'b10
   } fscr_state_e;
endpackage

/* rtl/fscr_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fscr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // meta_r feeds q only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* rtl/fscr_regs.sv */
// status and configuration registers of a serial flash, with spi front end
// Summary of operation
// - three status registers, own reads, own writes
// - busy flag at bit zero during operations
// - busy ignores all but read status, suspend
// - busy clears when operation finishes
// - write enable latch at bit one
// - latch cleared at power-up, writes, erases
// - three-bit protection level, writable
// - protection level defaults to zero
// - top/bottom select, default top
// - granularity select: sectors or blocks
// - complement bit at fourteen inverts protection
// - protect bit at seven selects pin control
// - lock bit at eight selects lock-down
// - protect zero: latch alone permits write
// - protect one, pin low: no write
// - protect one, pin high: latch permits
// - lock set holds until power cycle
// - permanent lock by special command flow
// - pin gating only in standard/dual mode
// - quad enable disables pin protection
`timescale 1ns/1ps
module fscr_regs #(
   parameter int STATUS_WRITE_TIME = fscr_pkg::STATUS_WRITE_CYCLES,
   parameter int ARRAY_OP_TIME = fscr_pkg::ARRAY_OP_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic SPI_CLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_DI,
   input wire logic WP_N,
   output logic SPI_DO,
   output logic SPI_DO_OE,
   output logic BUSY,
   output logic WRITE_ENABLE_LATCH,
   output logic [2:0] PROT_LEVEL,
   output logic TOP_BOTTOM_SELECT,
   output logic GRANULARITY_SELECT,
   output logic COMPLEMENT_PROTECT,
   output logic QUAD_ENABLE,
   output logic [7:0] STATUS_THREE,
   output logic SUSPEND_REQ
);
   import fscr_pkg::*;

   logic rst_meta_r;
   logic rst_n;
   logic [3:0] pins_s;
   logic sck_s;
   logic cs_n_s;
   logic di_s;
   logic wp_n_s;
   logic sck_d_r;
   logic cs_n_d_r;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   fscr_state_e state_r;
   logic [2:0] bit_cnt_r;
   logic [1:0] byte_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] new_byte;
   logic byte_done;
   logic [7:0] opcode_r;
   logic [7:0] data0_r;
   logic [7:0] data1_r;
   logic [7:0] tx_r;
   logic do_r;
   logic busy_r;
   logic [TIMER_W-1:0] timer_r;
   logic wel_r;
   logic [2:0] prot_level_r;
   logic top_bottom_r;
   logic granularity_r;
   logic complement_r;
   logic status_protect_r;
   logic status_lock_r;
   logic perm_lock_r;
   logic quad_enable_r;
   logic [7:0] status_three_r;
   logic suspend_r;
   logic [7:0] status_one;
   logic [7:0] status_two;
   logic [7:0] read_sel;
   logic is_read;
   logic is_array_op;
   logic is_write_status;
   logic allowed_busy;
   logic frame_end;
   logic write_ok;
   logic do_wren;
   logic do_wrdi;
   logic do_wrsr;
   logic do_perm;
   logic do_array;

   // reset release through two flops
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   fscr_sync #(
      .WIDTH(4),
      .RST_VAL(SYNC_RST)
   ) u_pin_sync (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .d({SPI_CLK, SPI_CS_N, SPI_DI, WP_N}),
      .q(pins_s)
   );

   assign sck_s = pins_s[3];
   assign cs_n_s = pins_s[2];
   assign di_s = pins_s[1];
   assign wp_n_s = pins_s[0];

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sck_d_r <= sck_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
   assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
   assign cs_fall = ~cs_n_s & cs_n_d_r;
   assign cs_rise = cs_n_s & ~cs_n_d_r;

   // status images
   always_comb begin
      status_one = 8'h00;
      status_one[SR1_BUSY] = busy_r;
      status_one[SR1_WEL] = wel_r;
      status_one[SR1_LVL_MSB:SR1_LVL_LSB] = prot_level_r;
      status_one[SR1_TB] = top_bottom_r;
      status_one[SR1_SEC] = granularity_r;
      status_one[SR1_SRP] = status_protect_r;
      status_two = 8'h00;
      status_two[SR2_SRL] = status_lock_r | perm_lock_r;
      status_two[SR2_QE] = quad_enable_r;
      status_two[SR2_CMP] = complement_r;
   end

   // instruction classes
   always_comb begin
      is_read = 1'b1;
      read_sel = status_one;
      if (opcode_r == OP_READ_STATUS1) begin
         read_sel = status_one;
      end else if (opcode_r == OP_READ_STATUS2) begin
         read_sel = status_two;
      end else if (opcode_r == OP_READ_STATUS3) begin
         read_sel = status_three_r;
      end else begin
         is_read = 1'b0;
      end
   end

   assign is_write_status = (opcode_r == OP_WRITE_STATUS1) || (opcode_r == OP_WRITE_STATUS2) ||
                            (opcode_r == OP_WRITE_STATUS3);
   assign is_array_op = (opcode_r == OP_PAGE_PROG) || (opcode_r == OP_QUAD_PROG) ||
                        (opcode_r == OP_SECTOR_ERASE) || (opcode_r == OP_BLOCK32_ERASE) ||
                        (opcode_r == OP_BLOCK64_ERASE) || (opcode_r == OP_CHIP_ERASE_A) ||
                        (opcode_r == OP_CHIP_ERASE_B) || (opcode_r == OP_SEC_REG_ERASE) ||
                        (opcode_r == OP_SEC_REG_PROG);

   assign new_byte = {shift_r[6:0], di_s};
   assign byte_done = sck_rise && (bit_cnt_r == LAST_BIT) && (state_r != ST_IDLE);
   assign allowed_busy = (new_byte == OP_READ_STATUS1) || (new_byte == OP_READ_STATUS2) ||
                         (new_byte == OP_READ_STATUS3) || (new_byte == OP_SUSPEND);
   // frame sequencing
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
      end else if (cs_n_s) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
      end else begin
         if (cs_fall) begin
            state_r <= ST_CMD;
         end
         if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
         case (state_r)
            ST_CMD: begin
               if (byte_done) begin
                  if (busy_r && !allowed_busy) begin
                     state_r <= ST_IGNORE;
                  end else begin
                     state_r <= ST_DATA;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // opcode and data capture
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= 8'h00;
         opcode_r <= 8'h00;
         data0_r <= 8'h00;
         data1_r <= 8'h00;
         byte_cnt_r <= 2'h0;
      end else begin
         if (sck_rise) begin
            shift_r <= new_byte;
         end
         if (byte_done && state_r == ST_CMD) begin
            opcode_r <= new_byte;
            byte_cnt_r <= 2'h0;
         end else if (byte_done && state_r == ST_DATA) begin
            if (byte_cnt_r == 2'h0) begin
               data0_r <= new_byte;
            end else if (byte_cnt_r == 2'h1) begin
               data1_r <= new_byte;
            end
            if (byte_cnt_r != BYTE_CNT_MAX) begin
               byte_cnt_r <= byte_cnt_r + 2'h1;
            end
         end
      end
   end

   // serial output: fresh value each byte, so busy polls see live state
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_r <= 8'h00;
         do_r <= 1'b0;
      end else if (sck_fall && state_r == ST_DATA && is_read) begin
         if (bit_cnt_r == 3'h0) begin
            do_r <= read_sel[7];
            tx_r <= {read_sel[6:0], 1'b0};
         end else begin
            do_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
         end
      end
   end

   assign SPI_DO = do_r;
   assign SPI_DO_OE = ~cs_n_s && (state_r == ST_DATA) && is_read;
   // suspend request pulse while an operation runs
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         suspend_r <= 1'b0;
      end else begin
         suspend_r <= byte_done && (state_r == ST_CMD) && busy_r && (new_byte == OP_SUSPEND);
      end
   end
   // commands act at deselect, and only after whole bytes
   assign frame_end = cs_rise && (state_r == ST_DATA) && (bit_cnt_r == 3'h0);
   // pin gating is off in quad mode, where the pin carries data
   assign write_ok = wel_r && !status_lock_r && !perm_lock_r &&
                     !(status_protect_r && !wp_n_s && !quad_enable_r);
   assign do_wren = frame_end && (opcode_r == OP_WRITE_ENABLE);
   assign do_wrdi = frame_end && (opcode_r == OP_WRITE_DISABLE);
   assign do_wrsr = frame_end && is_write_status && (byte_cnt_r != 2'h0) && write_ok;
   assign do_perm = frame_end && (opcode_r == OP_PERM_LOCK) && write_ok;
   assign do_array = frame_end && is_array_op && wel_r;

   // write enable latch
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         wel_r <= 1'b0;
      end else if (do_wrdi || do_wrsr || do_perm || do_array) begin
         wel_r <= 1'b0;
      end else if (do_wren) begin
         wel_r <= 1'b1;
      end
   end

   // operation timer; the array itself sits outside this block
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         timer_r <= '0;
      end else if (do_wrsr || do_perm) begin
         busy_r <= 1'b1;
         timer_r <= TIMER_W'(STATUS_WRITE_TIME);
      end else if (do_array) begin
         busy_r <= 1'b1;
         timer_r <= TIMER_W'(ARRAY_OP_TIME);
      end else if (busy_r) begin
         timer_r <= timer_r - TIMER_W'(1);
         if (timer_r <= TIMER_W'(1)) begin
            busy_r <= 1'b0;
         end
      end
   end

   // stored configuration; factory values come back on reset
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         prot_level_r <= RST_PROT_LEVEL;
         top_bottom_r <= RST_TOP_BOTTOM;
         granularity_r <= RST_GRANULARITY;
         status_protect_r <= RST_STATUS_PROTECT;
         complement_r <= RST_COMPLEMENT;
         quad_enable_r <= RST_QUAD_ENABLE;
         status_three_r <= RST_STATUS_THREE;
      end else if (do_wrsr) begin
         if (opcode_r == OP_WRITE_STATUS1) begin
            prot_level_r <= data0_r[SR1_LVL_MSB:SR1_LVL_LSB];
            top_bottom_r <= data0_r[SR1_TB];
            granularity_r <= data0_r[SR1_SEC];
            status_protect_r <= data0_r[SR1_SRP];
            if (byte_cnt_r != 2'h1) begin
               complement_r <= data1_r[SR2_CMP];
               quad_enable_r <= data1_r[SR2_QE];
            end
         end else if (opcode_r == OP_WRITE_STATUS2) begin
            complement_r <= data0_r[SR2_CMP];
            quad_enable_r <= data0_r[SR2_QE];
         end else begin
            status_three_r <= data0_r;
         end
      end
   end

   // lock-down is volatile; the one-time lock survives only as a flop here
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         status_lock_r <= 1'b0;
         perm_lock_r <= 1'b0;
      end else begin
         if (do_wrsr && opcode_r == OP_WRITE_STATUS1 && byte_cnt_r != 2'h1) begin
            status_lock_r <= data1_r[SR2_SRL];
         end else if (do_wrsr && opcode_r == OP_WRITE_STATUS2) begin
            status_lock_r <= data0_r[SR2_SRL];
         end
         if (do_perm) begin
            perm_lock_r <= 1'b1;
         end
      end
   end

   assign BUSY = busy_r;
   assign WRITE_ENABLE_LATCH = wel_r;
   assign PROT_LEVEL = prot_level_r;
   assign TOP_BOTTOM_SELECT = top_bottom_r;
   assign GRANULARITY_SELECT = granularity_r;
   assign COMPLEMENT_PROTECT = complement_r;
   assign QUAD_ENABLE = quad_enable_r;
   assign STATUS_THREE = status_three_r;
   assign SUSPEND_REQ = suspend_r;
endmodule

/* bench/fscr_host.sv */
// host serial controller model for the status register block
`timescale 1ns/1ps
module fscr_host (
   input wire logic core_clk,
   input wire logic spi_do,
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_di,
   output logic rd_valid,
   output logic [7:0] rd_byte
);
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_di = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
   end
   // pins move just after a core edge, never racing the sampler
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // serial clock stands low outside frames
   task automatic start();
      spi_cs_n = 1'b0;
      tick(4);
   endtask
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         spi_di = b[i];
         tick(4);
         spi_clk = 1'b1;
         tick(4);
         spi_clk = 1'b0;
      end
   endtask
   // sampled late in the high phase: output only moves after a fall
   task automatic get();
      logic [7:0] b;
      for (int i = 7; i >= 0; i--) begin
         spi_di = ~spi_di;
         tick(4);
         spi_clk = 1'b1;
         tick(3);
         b[i] = spi_do;
         tick(1);
         spi_clk = 1'b0;
      end
      rd_byte = b;
      rd_valid = 1'b1;
      tick(1);
      rd_valid = 1'b0;
   endtask
   // released data line flips, so a stale bit never passes for data
   task automatic stop();
      spi_cs_n = 1'b1;
      spi_di = ~spi_di;
      tick(8);
   endtask
endmodule

/* bench/fscr_regs_asserts.sv */
// port assertions for the status register block
`timescale 1ns/1ps
module fscr_regs_asserts #(
   parameter int STATUS_WRITE_TIME = 600,
   parameter int ARRAY_OP_TIME = 120000
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic SPI_CLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_DI,
   input wire logic WP_N,
   input wire logic SPI_DO,
   input wire logic SPI_DO_OE,
   input wire logic BUSY,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic [2:0] PROT_LEVEL,
   input wire logic TOP_BOTTOM_SELECT,
   input wire logic GRANULARITY_SELECT,
   input wire logic COMPLEMENT_PROTECT,
   input wire logic QUAD_ENABLE,
   input wire logic [7:0] STATUS_THREE,
   input wire logic SUSPEND_REQ
);
   int busy_cnt;
   logic [15:0] flds;
   assign flds = {STATUS_THREE, COMPLEMENT_PROTECT, QUAD_ENABLE, GRANULARITY_SELECT,
      TOP_BOTTOM_SELECT, PROT_LEVEL, 1'b0};
   // busy cycles, so operation time is checked to within one cycle
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= BUSY ? busy_cnt + 1 : 0;
      end
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_cs_idle;
      SPI_CS_N [*6];
   endsequence
   sequence s_busy_run;
      BUSY ##1 BUSY;
   endsequence
   property p_busy_len;
      $fell(BUSY) |-> (busy_cnt >= STATUS_WRITE_TIME - 1 && busy_cnt <= STATUS_WRITE_TIME + 1)
         || (busy_cnt >= ARRAY_OP_TIME - 1 && busy_cnt <= ARRAY_OP_TIME + 1);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy time wrong");
   property p_busy_start;
      $rose(BUSY) |-> $past(WRITE_ENABLE_LATCH) && $past(SPI_CS_N, 3);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy without latch");
   property p_fields_cause;
      $changed(flds) |-> $rose(BUSY) && $past(WRITE_ENABLE_LATCH);
   endproperty
   a_fields_cause: assert property (p_fields_cause) else $error("field changed unasked");
   property p_frozen;
      s_busy_run |-> $stable(flds);
   endproperty
   a_frozen: assert property (p_frozen) else $error("field changed while busy");
   property p_oe_idle;
      s_cs_idle |-> !SPI_DO_OE;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
   property p_sus_pulse;
      SUSPEND_REQ |-> BUSY ##1 !SUSPEND_REQ;
   endproperty
   a_sus_pulse: assert property (p_sus_pulse) else $error("suspend pulse wrong");
   property p_wel_set;
      $rose(WRITE_ENABLE_LATCH) |-> !BUSY && $past(SPI_CS_N, 3);
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch set wrongly");
   property p_wel_clr;
      $fell(WRITE_ENABLE_LATCH) |-> $past(SPI_CS_N, 3);
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("latch cleared mid frame");
   // read data moves only while driven, and only after a serial clock fall
   property p_do_move;
      $changed(SPI_DO) |-> $past(SPI_DO_OE) && !$past(SPI_CLK);
   endproperty
   a_do_move: assert property (p_do_move) else $error("data out moved wrongly");
endmodule
bind fscr_regs fscr_regs_asserts #(.STATUS_WRITE_TIME(STATUS_WRITE_TIME), .ARRAY_OP_TIME(ARRAY_OP_TIME))
   fscr_regs_asserts_i (.CORE_CLK, .RESETN, .SPI_CLK, .SPI_CS_N, .SPI_DI, .WP_N, .SPI_DO, .SPI_DO_OE,
   .BUSY, .WRITE_ENABLE_LATCH, .PROT_LEVEL, .TOP_BOTTOM_SELECT, .GRANULARITY_SELECT,
   .COMPLEMENT_PROTECT, .QUAD_ENABLE, .STATUS_THREE, .SUSPEND_REQ);

/* bench/tb_fscr_regs.sv */
// self-checking bench for the status register block
`timescale 1ns/1ps
module tb_fscr_regs;
   import fscr_pkg::*;
   localparam int SWT = 400;
   localparam int AOT = 600;
   localparam int LIMIT = 40000;
   logic CORE_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic WP_N = 1'b1;
   logic SPI_CLK, SPI_CS_N, SPI_DI, SPI_DO, SPI_DO_OE, BUSY, WRITE_ENABLE_LATCH;
   logic TOP_BOTTOM_SELECT, GRANULARITY_SELECT, COMPLEMENT_PROTECT, QUAD_ENABLE, SUSPEND_REQ, rd_valid;
   logic [2:0] PROT_LEVEL;
   logic [7:0] STATUS_THREE, rd_byte;
   logic [7:0] exp_q[$];
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   int sus_seen = 0;
   initial begin
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   fscr_regs #(.STATUS_WRITE_TIME(SWT), .ARRAY_OP_TIME(AOT)) fscr_regs_i (.CORE_CLK, .RESETN, .SPI_CLK,
      .SPI_CS_N, .SPI_DI, .WP_N, .SPI_DO, .SPI_DO_OE, .BUSY, .WRITE_ENABLE_LATCH, .PROT_LEVEL,
      .TOP_BOTTOM_SELECT, .GRANULARITY_SELECT, .COMPLEMENT_PROTECT, .QUAD_ENABLE, .STATUS_THREE, .SUSPEND_REQ);
   fscr_host fscr_host_i (.core_clk(CORE_CLK), .spi_do(SPI_DO), .spi_clk(SPI_CLK), .spi_cs_n(SPI_CS_N),
      .spi_di(SPI_DI), .rd_valid, .rd_byte);
   task automatic stop_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      fscr_host_i.start();
      fscr_host_i.put(op);
      fscr_host_i.stop();
   endtask
   task automatic wr(input logic [7:0] op, input logic [7:0] b);
      fscr_host_i.start();
      fscr_host_i.put(op);
      fscr_host_i.put(b);
      fscr_host_i.stop();
   endtask
   task automatic wr2(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
      fscr_host_i.start();
      fscr_host_i.put(op);
      fscr_host_i.put(b1);
      fscr_host_i.put(b2);
      fscr_host_i.stop();
   endtask
   // three address bytes keep the frame whole
   task automatic prog(input logic [7:0] op);
      fscr_host_i.start();
      fscr_host_i.put(op);
      repeat (3) fscr_host_i.put(8'($urandom()));
      fscr_host_i.stop();
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] e);
      exp_q.push_back(e);
      fscr_host_i.start();
      fscr_host_i.put(op);
      fscr_host_i.get();
      chk("output enable", 8'h01, {7'h00, SPI_DO_OE});
      fscr_host_i.stop();
      chk("output enable", 8'h00, {7'h00, SPI_DO_OE});
   endtask
   task automatic poll();
      int n;
      n = 0;
      while (BUSY !== 1'b0 && n < 2000) begin
         @(posedge CORE_CLK);
         #1;
         n++;
      end
      chk("busy done", 8'h00, {7'h00, BUSY});
   endtask
   task automatic do_reset();
      RESETN = 1'b0;
      repeat (5) @(posedge CORE_CLK);
      #1 RESETN = 1'b1;
      repeat (6) @(posedge CORE_CLK);
      #1;
   endtask
   always @(posedge rd_valid) begin
      if (exp_q.size() == 0) begin
         miscompares++;
         $display("[ERR] status read expected none seen %h", rd_byte);
      end else begin
         chk("status read", exp_q.pop_front(), rd_byte);
      end
   end
   // counted on the falling edge, away from the launching edge
   always @(negedge CORE_CLK) begin
      if (SUSPEND_REQ === 1'b1) sus_seen++;
   end
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("[ERR] run length expected below %0d seen %0d", LIMIT, cycles);
         stop_test();
      end
   end
   initial begin
      logic [7:0] b1;
      logic [7:0] ops [9];
      ops = '{OP_PAGE_PROG, OP_QUAD_PROG, OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE,
         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SEC_REG_ERASE, OP_SEC_REG_PROG};
      void'($urandom(32'h2c26));
      do_reset();
      rd(OP_READ_STATUS1, 8'h00);
      rd(OP_READ_STATUS2, 8'h00);
      rd(OP_READ_STATUS3, RST_STATUS_THREE);
      $display("test defaults done");
      cmd(OP_WRITE_ENABLE);
      rd(OP_READ_STATUS1, 8'h02);
      cmd(OP_WRITE_DISABLE);
      rd(OP_READ_STATUS1, 8'h00);
      b1 = 8'($urandom()) & 8'h7C;
      wr(OP_WRITE_STATUS1, b1);
      rd(OP_READ_STATUS1, 8'h00);
      cmd(OP_WRITE_ENABLE);
      wr2(OP_WRITE_STATUS1, b1, 8'h40);
      cmd(OP_WRITE_ENABLE);
      rd(OP_READ_STATUS1, b1 | 8'h01);
      poll();
      rd(OP_READ_STATUS1, b1);
      rd(OP_READ_STATUS2, 8'h40);
      chk("field pins", {b1[6:2], 3'h4}, {GRANULARITY_SELECT, TOP_BOTTOM_SELECT, PROT_LEVEL,
         COMPLEMENT_PROTECT, QUAD_ENABLE, 1'b0});
      b1 = 8'($urandom());
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS3, b1);
      poll();
      rd(OP_READ_STATUS3, b1);
      chk("status three pins", b1, STATUS_THREE);
      $display("test status write done");
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS1, 8'h80);
      poll();
      WP_N = 1'b0;
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS1, 8'h84);
      rd(OP_READ_STATUS1, 8'h82);
      WP_N = 1'b1;
      wr(OP_WRITE_STATUS1, 8'h88);
      poll();
      rd(OP_READ_STATUS1, 8'h88);
      cmd(OP_WRITE_ENABLE);
      wr2(OP_WRITE_STATUS1, 8'h80, 8'h02);
      poll();
      WP_N = 1'b0;
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS1, 8'h8C);
      poll();
      rd(OP_READ_STATUS1, 8'h8C);
      rd(OP_READ_STATUS2, 8'h02);
      WP_N = 1'b1;
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS2, 8'h40);
      poll();
      rd(OP_READ_STATUS2, 8'h40);
      $display("test pin gating done");
      prog(OP_PAGE_PROG);
      chk("busy without latch", 8'h00, {7'h00, BUSY});
      foreach (ops[i]) begin
         cmd(OP_WRITE_ENABLE);
         prog(ops[i]);
         chk("busy and latch", 8'h02, {6'h00, BUSY, WRITE_ENABLE_LATCH});
         cmd(OP_SUSPEND);
         poll();
      end
      chk("suspend pulses", 8'h09, 8'(sus_seen));
      $display("test array operations done");
      cmd(OP_WRITE_ENABLE);
      wr2(OP_WRITE_STATUS1, 8'h00, 8'h01);
      poll();
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS2, 8'h00);
      rd(OP_READ_STATUS2, 8'h01);
      rd(OP_READ_STATUS1, 8'h02);
      do_reset();
      rd(OP_READ_STATUS2, 8'h00);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_PERM_LOCK);
      poll();
      cmd(OP_WRITE_ENABLE);
      wr(OP_WRITE_STATUS3, 8'h5A);
      rd(OP_READ_STATUS3, 8'h00);
      rd(OP_READ_STATUS2, 8'h01);
      $display("test locks done");
      stop_test();
   end
endmodule
